/* rtl/t2c_pkg.sv */
// Package for the sixteen-bit timer/counter with capture, reload and baud modes.
// Assumes a byte-wide register port with eight-bit addresses.
package t2c_pkg;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] T2C_ADDR_CONTROL = 8'hc8;
    localparam logic [7:0] T2C_ADDR_MODE = 8'hc9;
    localparam logic [7:0] T2C_ADDR_RELOAD_LOW = 8'hca;
    localparam logic [7:0] T2C_ADDR_RELOAD_HIGH = 8'hcb;
    localparam logic [7:0] T2C_ADDR_COUNT_LOW = 8'hcc;
    localparam logic [7:0] T2C_ADDR_COUNT_HIGH = 8'hcd;

    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int T2C_CTRL_OVF_BIT = 7;
    localparam int T2C_CTRL_EXT_BIT = 6;
    localparam int T2C_MODE_DOWN_COUNT_ENABLE_BIT = 0;
    localparam int T2C_MODE_OE_BIT = 1;
    localparam logic [7:0] T2C_CONTROL_RESET = 8'h00;
    localparam logic [1:0] T2C_MODE_RESET = 2'h0;
    localparam logic [15:0] T2C_RELOAD_RESET = 16'h0000;
    localparam logic [15:0] T2C_COUNT_RESET = 16'h0000;
    localparam logic [15:0] T2C_COUNT_TOP = 16'hffff;

    // ****************************************
    // Timing counts (clk_sys is the oscillator)
    // ****************************************
    localparam int T2C_TIMER_DIV = 12;
    localparam int T2C_BAUD_DIV = 2;
    localparam int T2C_BAUD_OVF_PER_BIT = 16;

    // Control register image, bit 7 down to bit 0
    typedef struct packed {
        logic overflow_flag;
        logic external_flag;
        logic rx_clock_select;
        logic tx_clock_select;
        logic ext_trigger_enable;
        logic run_control;
        logic count_source_select;
        logic capture_reload_select;
    } t2c_ctrl_t;

    // Register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } t2c_req_t;

endpackage : t2c_pkg

/* rtl/t2c_edge_sync.sv */
// Two-stage synchroniser with a falling-edge detector behind it.
// Assumes the pin may change at any time relative to clk_sys.
`timescale 1ns/1ps
module t2c_edge_sync
    import t2c_pkg::*;
(
    input wire logic clk_sys, // System clock
    input wire logic rst, // Synchronous reset, active high
    input wire logic pin_in, // Asynchronous pin level
    output logic level_o, // Synchronised level
    output logic fall_o // One-cycle pulse on a high-to-low change
);
    logic meta_r;
    logic sync_r;
    logic last_r;

    // First stage feeds only the second
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            meta_r <= 1'b1;
            sync_r <= 1'b1;
            last_r <= 1'b1;
        end
        else
        begin
            meta_r <= pin_in;
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end

    assign level_o = sync_r;
    assign fall_o = last_r & ~sync_r;

endmodule : t2c_edge_sync

/* rtl/t2c_timer.sv */
// Sixteen-bit timer/counter: capture, auto-reload (up or down) and baud generation.
// Assumes a byte register port, clk_sys as oscillator, and a partner timer's overflow.
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
module t2c_timer
    import t2c_pkg::*;
#(
    parameter int TIMER_DIV = T2C_TIMER_DIV, // Clocks per tick, timer mode
    parameter int BAUD_DIV = T2C_BAUD_DIV // Clocks per tick, baud mode
)
(
    input wire logic clk_sys, // System clock, 50 MHz
    input wire logic rst, // Synchronous reset, active high
    input wire logic [7:0] reg_addr, // Register address
    input wire logic [7:0] reg_wdata, // Register write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [7:0] reg_rdata, // Read data, cycle after the strobe
    input wire logic trigger_input, // Capture/reload/direction pin
    input wire logic external_count_input, // Event count pin
    input wire logic timer_int_enable, // Interrupt enable from the controller
    input wire logic other_timer_ovf, // Partner timer overflow pulse
    output logic timer_irq, // Interrupt request level
    output logic rx_baud_clk, // Receiver baud clock pulse
    output logic tx_baud_clk // Transmitter baud clock pulse
);

    // ****************************************
    // Parameter checks
    // ****************************************
    if (TIMER_DIV < 1 || TIMER_DIV > 255 || BAUD_DIV < 1 || BAUD_DIV > 255)
    begin : g_bad_div
        $error("t2c_timer: divider out of range");
    end

    t2c_req_t req;
    t2c_ctrl_t ctrl_r;
    logic [1:0] mode_r;
    logic [15:0] reload_r;
    logic [15:0] count_r;
    logic [7:0] presc_r;
    logic [7:0] reg_rdata_r;
    logic trig_level;
    logic trig_fall;
    logic cnt_fall;

    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [1:0] pin_in;
    logic [1:0] pin_level;
    logic [1:0] pin_fall;
    assign pin_in = {external_count_input, trigger_input};

    for (genvar i = 0; i < 2; i++)
    begin : g_sync
        t2c_edge_sync u_sync (
            .clk_sys(clk_sys),
            .rst(rst),
            .pin_in(pin_in[i]),
            .level_o(pin_level[i]),
            .fall_o(pin_fall[i])
        );
    end

    assign trig_level = pin_level[0];
    assign trig_fall = pin_fall[0];
    assign cnt_fall = pin_fall[1];

    // ****************************************
    // Mode decode
    // ****************************************
    logic baud_mode;
    logic down_count_enable;
    logic down_count_enable_mode;
    logic count_up;
    logic ext_evt;
    logic capture_evt;
    logic ext_reload_evt;
    logic tick;
    logic presc_done;
    logic ovf_evt;
    logic udf_evt;

    assign baud_mode = ctrl_r.rx_clock_select | ctrl_r.tx_clock_select;
    assign down_count_enable = mode_r[T2C_MODE_DOWN_COUNT_ENABLE_BIT];
    // Trigger pin steers direction only in plain auto-reload with down count enabled
    assign down_count_enable_mode = down_count_enable & ~ctrl_r.capture_reload_select & ~baud_mode;
    assign count_up = ~down_count_enable_mode | trig_level;

    // Trigger events; in direction mode the pin is a level, not an event source
    assign ext_evt = ctrl_r.ext_trigger_enable & trig_fall & ~down_count_enable_mode;
    assign capture_evt = ext_evt & ctrl_r.capture_reload_select & ~baud_mode;
    assign ext_reload_evt = ext_evt & ~ctrl_r.capture_reload_select & ~baud_mode;

    // ****************************************
    // Prescaler and tick source
    // ****************************************
    logic [7:0] div_sel;
    assign div_sel = baud_mode ? 8'(BAUD_DIV - 1) : 8'(TIMER_DIV - 1);
    assign presc_done = (presc_r >= div_sel);

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            presc_r <= 8'h00;
        end
        else if (!ctrl_r.run_control || presc_done)
        begin
            presc_r <= 8'h00;
        end
        else
        begin
            presc_r <= presc_r + 8'h01;
        end
    end

    assign tick = ctrl_r.run_control & (ctrl_r.count_source_select ? cnt_fall : presc_done);
    assign ovf_evt = tick & count_up & (count_r == T2C_COUNT_TOP);
    assign udf_evt = tick & ~count_up & (count_r == reload_r);

    // ****************************************
    // Counter
    // ****************************************
    logic wr_cnt_lo;
    logic wr_cnt_hi;
    assign wr_cnt_lo = req.wr && (req.addr == T2C_ADDR_COUNT_LOW);
    assign wr_cnt_hi = req.wr && (req.addr == T2C_ADDR_COUNT_HIGH);

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            count_r <= T2C_COUNT_RESET;
        end
        else if (wr_cnt_lo)
        begin
            count_r <= {count_r[15:8], req.wdata};
        end
        else if (wr_cnt_hi)
        begin
            count_r <= {req.wdata, count_r[7:0]};
        end
        else if (ext_reload_evt)
        begin
            count_r <= reload_r;
        end
        else if (ovf_evt && (baud_mode || !ctrl_r.capture_reload_select))
        begin
            count_r <= reload_r;
        end
        else if (udf_evt)
        begin
            count_r <= T2C_COUNT_TOP;
        end
        else if (tick)
        begin
            count_r <= count_up ? count_r + 16'h0001 : count_r - 16'h0001;
        end
    end

    // ****************************************
    // Reload / capture registers
    // ****************************************
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            reload_r <= T2C_RELOAD_RESET;
        end
        else if (capture_evt)
        begin
            // Capture beats a software write in the same cycle
            reload_r <= count_r;
        end
        else if (req.wr && req.addr == T2C_ADDR_RELOAD_LOW)
        begin
            reload_r <= {reload_r[15:8], req.wdata};
        end
        else if (req.wr && req.addr == T2C_ADDR_RELOAD_HIGH)
        begin
            reload_r <= {req.wdata, reload_r[7:0]};
        end
    end

    // ****************************************
    // Control and mode registers
    // ****************************************
    logic wr_ctrl;
    logic ovf_set;
    logic exf_set;
    logic exf_toggle;
    assign wr_ctrl = req.wr && (req.addr == T2C_ADDR_CONTROL);
    assign ovf_set = (ovf_evt | udf_evt) & ~baud_mode;
    assign exf_set = ext_evt;
    assign exf_toggle = down_count_enable_mode & (ovf_evt | udf_evt);

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            ctrl_r <= t2c_ctrl_t'(T2C_CONTROL_RESET);
        end
        else if (wr_ctrl)
        begin
            ctrl_r <= t2c_ctrl_t'(req.wdata);
            // A hardware event in the clearing cycle wins
            if (ovf_set)
            begin
                ctrl_r.overflow_flag <= 1'b1;
            end
            if (exf_set)
            begin
                ctrl_r.external_flag <= 1'b1;
            end
            else if (exf_toggle)
            begin
                ctrl_r.external_flag <= ~req.wdata[T2C_CTRL_EXT_BIT];
            end
        end
        else
        begin
            if (ovf_set)
            begin
                ctrl_r.overflow_flag <= 1'b1;
            end
            if (exf_set)
            begin
                ctrl_r.external_flag <= 1'b1;
            end
            else if (exf_toggle)
            begin
                ctrl_r.external_flag <= ~ctrl_r.external_flag;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            mode_r <= T2C_MODE_RESET;
        end
        else if (req.wr && req.addr == T2C_ADDR_MODE)
        begin
            mode_r <= req.wdata[1:0];
        end
    end

    // ****************************************
    // Read port
    // ****************************************
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            reg_rdata_r <= 8'h00;
        end
        else if (req.rd)
        begin
            if (req.addr == T2C_ADDR_CONTROL)
            begin
                reg_rdata_r <= ctrl_r;
            end
            else if (req.addr == T2C_ADDR_MODE)
            begin
                reg_rdata_r <= {6'h00, mode_r};
            end
            else if (req.addr == T2C_ADDR_RELOAD_LOW)
            begin
                reg_rdata_r <= reload_r[7:0];
            end
            else if (req.addr == T2C_ADDR_RELOAD_HIGH)
            begin
                reg_rdata_r <= reload_r[15:8];
            end
            else if (req.addr == T2C_ADDR_COUNT_LOW)
            begin
                reg_rdata_r <= count_r[7:0];
            end
            else if (req.addr == T2C_ADDR_COUNT_HIGH)
            begin
                reg_rdata_r <= count_r[15:8];
            end
            else
            begin
                reg_rdata_r <= 8'h00;
            end
        end
        else
        begin
            reg_rdata_r <= 8'h00;
        end
    end

    assign reg_rdata = reg_rdata_r;

    // ****************************************
    // Interrupt and serial clocks
    // ****************************************
    assign timer_irq = timer_int_enable &
        (ctrl_r.overflow_flag | (ctrl_r.external_flag & ~down_count_enable));
    // Serial port divides these pulses by 16 to get its bit rate
    assign rx_baud_clk = ctrl_r.rx_clock_select ? ovf_evt : other_timer_ovf;
    assign tx_baud_clk = ctrl_r.tx_clock_select ? ovf_evt : other_timer_ovf;

    // ****************************************
    // Assertions
    // ****************************************
    // Spacing monitor: clocks since the last tick, and whether it was an internal one
    logic [7:0] tick_gap_r;
    logic int_tick_r;
    always_ff @(posedge clk_sys)
    begin
        if (rst || !ctrl_r.run_control)
        begin
            tick_gap_r <= 8'h00;
            int_tick_r <= 1'b0;
        end
        else if (tick)
        begin
            tick_gap_r <= 8'h00;
            int_tick_r <= !ctrl_r.count_source_select && !baud_mode;
        end
        else if (tick_gap_r != 8'hff)
        begin
            tick_gap_r <= tick_gap_r + 8'h01;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    a_ovf_flag_set: assert property ((ovf_evt && !baud_mode) |=> ctrl_r.overflow_flag)
        else $error("overflow flag not set after overflow");
    a_no_flag_baud: assert property (
        (!ctrl_r.overflow_flag && baud_mode && !wr_ctrl) |=> !ctrl_r.overflow_flag)
        else $error("overflow flag set in baud mode");
    a_ext_flag_set: assert property (ext_evt |=> ctrl_r.external_flag)
        else $error("external flag not set on trigger");
    a_irq_level: assert property (
        timer_irq == (timer_int_enable && (ctrl_r.overflow_flag ||
        (ctrl_r.external_flag && !down_count_enable))))
        else $error("interrupt request mismatch");
    a_stopped_hold: assert property (
        (!ctrl_r.run_control && !req.wr && !ext_reload_evt) |=> $stable(count_r))
        else $error("count moved while stopped");
    a_timer_div: assert property (
        (tick && !ctrl_r.count_source_select && !baud_mode && int_tick_r)
        |-> (tick_gap_r >= 8'(TIMER_DIV - 1)))
        else $error("internal tick faster than one in twelve");
    a_up_reload: assert property (
        (ovf_evt && !ctrl_r.capture_reload_select && !req.wr && !ext_reload_evt)
        |=> count_r == $past(reload_r))
        else $error("no reload on overflow");
    a_capture_copy: assert property (
        capture_evt |=> (reload_r == $past(count_r)))
        else $error("capture did not copy count");
    a_down_load: assert property (
        (udf_evt && !req.wr && !ext_reload_evt) |=> count_r == T2C_COUNT_TOP)
        else $error("underflow did not load top");
    a_tx_clock: assert property (
        ctrl_r.tx_clock_select |-> (tx_baud_clk == ovf_evt))
        else $error("transmit clock not from own overflow");

    c_capture: cover property (capture_evt);
    c_ext_reload: cover property (ext_reload_evt);
    c_baud_ovf: cover property (ovf_evt && baud_mode);
    c_underflow: cover property (udf_evt);

endmodule : t2c_timer

/* dv/t2c_pin_model.sv */
// Pin partner for the timer: drives the trigger pin and the event-count pin.
// Assumes both pins rest high through the port pull-ups when nothing pulls them.
`timescale 1ns/1ps
module t2c_pin_model
(
    input wire logic clk_sys, // System clock
    input wire logic rst, // Reset, active high
    input wire logic trig_low, // Hold the trigger pin low
    input wire logic cnt_fall, // Pulse: start one low phase on the event pin
    input wire logic [1:0] low_len, // Extra low cycles, slow or prompt events
    output logic trigger_input, // Trigger pin level
    output logic external_count_input // Event pin level
);
    logic [2:0] low_cnt_r;

    assign trigger_input = ~trig_low;

    // Low phase lasts at least two samples, else the synchroniser could miss it
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            low_cnt_r <= 3'h0;
        else if (cnt_fall)
            low_cnt_r <= {1'b0, low_len} + 3'h2;
        else if (low_cnt_r != 3'h0)
            low_cnt_r <= low_cnt_r - 3'h1;
    end

    assign external_count_input = (low_cnt_r == 3'h0);
endmodule : t2c_pin_model

/* dv/t2c_timer_tb.sv */
// Self-checking bench for the timer: register tasks, pin partner, read-data queue.
// Assumes one-cycle read data and a three-cycle pin path inside the timer.
`timescale 1ns/1ps
module t2c_timer_tb import t2c_pkg::*;;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic trigger_input;
    logic external_count_input;
    logic trig_low = 1'b0;
    logic cnt_fall = 1'b0;
    logic [1:0] low_len = 2'h0;
    logic int_en = 1'b0;
    logic oth_ovf = 1'b0;
    logic timer_irq;
    logic rx_baud_clk;
    logic tx_baud_clk;
    logic rd_seen = 1'b0;
    logic [7:0] exp_q[$];
    logic [15:0] r;
    logic [7:0] v;
    int error_cnt = 0;
    int cmp_count = 0;
    int rx_n;

    t2c_timer t2c_timer_i (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .trigger_input(trigger_input), .external_count_input(external_count_input),
        .timer_int_enable(int_en), .other_timer_ovf(oth_ovf), .timer_irq(timer_irq),
        .rx_baud_clk(rx_baud_clk), .tx_baud_clk(tx_baud_clk));

    t2c_pin_model t2c_pin_model_i (.clk_sys(clk_sys), .rst(rst), .trig_low(trig_low),
        .cnt_fall(cnt_fall), .low_len(low_len), .trigger_input(trigger_input),
        .external_count_input(external_count_input));

    initial
    begin
        forever #10 clk_sys = ~clk_sys;
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic results;
        $display("Compares %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : results

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : cyc

    // A gap cycle follows each strobe so no strobe is assigned twice in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        @(posedge clk_sys);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        exp_q.push_back(exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(posedge clk_sys);
    endtask : rd

    task automatic wr16(input logic [7:0] a, input logic [15:0] d);
        wr(a, d[7:0]);
        wr(a + 8'h01, d[15:8]);
    endtask : wr16

    task automatic rd16(input logic [7:0] a, input logic [15:0] d);
        rd(a, d[7:0]);
        rd(a + 8'h01, d[15:8]);
    endtask : rd16

    task automatic trig_edge;
        trig_low <= 1'b1;
        cyc(4);
        trig_low <= 1'b0;
        cyc(4);
    endtask : trig_edge

    // Read data stands only in the cycle after the strobe
    always @(posedge clk_sys)
    begin
        if (rd_seen)
            chk(reg_rdata, exp_q.pop_front());
        rd_seen <= reg_rd;
    end

    initial
    begin
        cyc(100000);
        error_cnt++;
        $display("unexpected timeout at %0t: got %h expected %h", $time, 8'h00, 8'h01);
        results();
    end

    // ****************************************
    // Scenarios
    // ****************************************
    initial
    begin
        void'($urandom(16850));
        cyc(6);
        rst <= 1'b0;
        @(posedge clk_sys);
        for (int i = 0; i < 6; i++)
            rd(T2C_ADDR_CONTROL + 8'(i), 8'h00);
        rd(8'h00, 8'h00);
        v = 8'($urandom) & 8'hfb;
        wr(T2C_ADDR_CONTROL, v);
        rd(T2C_ADDR_CONTROL, v);
        wr(T2C_ADDR_CONTROL, 8'h00);
        r = 16'($urandom);
        wr16(T2C_ADDR_RELOAD_LOW, r);
        rd16(T2C_ADDR_RELOAD_LOW, r);
        $display("test registers done");
        wr16(T2C_ADDR_COUNT_LOW, 16'h0000);
        wr(T2C_ADDR_CONTROL, 8'h04);
        cyc(64);
        wr(T2C_ADDR_CONTROL, 8'h00);
        rd16(T2C_ADDR_COUNT_LOW, 16'h0005);
        cyc(30);
        rd16(T2C_ADDR_COUNT_LOW, 16'h0005);
        $display("test timer done");
        int_en <= 1'b1;
        wr16(T2C_ADDR_RELOAD_LOW, 16'h1234);
        wr16(T2C_ADDR_COUNT_LOW, 16'hfffe);
        wr(T2C_ADDR_CONTROL, 8'h04);
        cyc(28);
        rd(T2C_ADDR_CONTROL, 8'h84);
        wr(T2C_ADDR_CONTROL, 8'h80);
        rd(T2C_ADDR_CONTROL, 8'h80);
        rd16(T2C_ADDR_COUNT_LOW, 16'h1234);
        chk({7'h00, timer_irq}, 8'h01);
        wr(T2C_ADDR_CONTROL, 8'h00);
        chk({7'h00, timer_irq}, 8'h00);
        $display("test reload done");
        r = 16'($urandom);
        wr16(T2C_ADDR_COUNT_LOW, r);
        wr16(T2C_ADDR_RELOAD_LOW, ~r);
        wr(T2C_ADDR_CONTROL, 8'h09);
        trig_edge();
        rd16(T2C_ADDR_RELOAD_LOW, r);
        rd16(T2C_ADDR_COUNT_LOW, r);
        rd(T2C_ADDR_CONTROL, 8'h49);
        chk({7'h00, timer_irq}, 8'h01);
        wr(T2C_ADDR_CONTROL, 8'h01);
        wr16(T2C_ADDR_RELOAD_LOW, 16'h0000);
        trig_edge();
        rd16(T2C_ADDR_RELOAD_LOW, 16'h0000);
        rd(T2C_ADDR_CONTROL, 8'h01);
        wr(T2C_ADDR_CONTROL, 8'h08);
        wr16(T2C_ADDR_RELOAD_LOW, 16'h5a5a);
        trig_edge();
        rd16(T2C_ADDR_COUNT_LOW, 16'h5a5a);
        rd(T2C_ADDR_CONTROL, 8'h48);
        $display("test trigger done");
        wr16(T2C_ADDR_COUNT_LOW, 16'h0000);
        wr(T2C_ADDR_CONTROL, 8'h06);
        repeat (3)
        begin
            low_len <= 2'($urandom);
            cnt_fall <= 1'b1;
            @(posedge clk_sys);
            cnt_fall <= 1'b0;
            cyc(9);
        end
        wr(T2C_ADDR_CONTROL, 8'h00);
        rd16(T2C_ADDR_COUNT_LOW, 16'h0003);
        $display("test events done");
        // Capture select set on purpose: baud mode must still reload
        wr16(T2C_ADDR_RELOAD_LOW, 16'hfffe);
        wr16(T2C_ADDR_COUNT_LOW, 16'hfffe);
        for (int k = 0; k < 2; k++)
        begin
            wr(T2C_ADDR_CONTROL, k ? 8'h15 : 8'h25);
            rx_n = 0;
            repeat (80)
            begin
                @(posedge clk_sys);
                chk({7'h00, k ? rx_baud_clk : tx_baud_clk}, {7'h00, oth_ovf});
                rx_n += k ? int'(tx_baud_clk) : int'(rx_baud_clk);
                oth_ovf <= 1'($urandom);
            end
            if (rx_n >= 19 && rx_n <= 21)
                rx_n = 20;
            chk(8'(rx_n), 8'h14);
            rd(T2C_ADDR_CONTROL, k ? 8'h15 : 8'h25);
        end
        wr(T2C_ADDR_CONTROL, 8'h00);
        $display("test baud done");
        wr(T2C_ADDR_MODE, 8'h01);
        wr16(T2C_ADDR_RELOAD_LOW, 16'h4000);
        wr16(T2C_ADDR_COUNT_LOW, 16'h4000);
        trig_low <= 1'b1;
        cyc(4);
        wr(T2C_ADDR_CONTROL, 8'h04);
        cyc(16);
        rd(T2C_ADDR_CONTROL, 8'hc4);
        wr(T2C_ADDR_CONTROL, 8'hc0);
        rd16(T2C_ADDR_COUNT_LOW, 16'hffff);
        rd(T2C_ADDR_CONTROL, 8'hc0);
        wr(T2C_ADDR_CONTROL, 8'h40);
        chk({7'h00, timer_irq}, 8'h00);
        trig_low <= 1'b0;
        $display("test down count done");
        results();
    end
endmodule : t2c_timer_tb
